// ==== design/umim_io_map.sv ====
// umim_io_map: i/o register decode, stack pointers, program counter,
// data ram and protected program read path of a low-speed usb controller
// assumes: core issues at most one i/o or stack operation per cycle,
// all inputs synchronous to clock
`timescale 1ns/100ps
module umim_io_map #(
  parameter int PROG_BYTES = umim_pkg::PROG_SMALL_BYTES,
  parameter int P1_PINS = umim_pkg::PORT_PINS
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic osc_in,
  output logic core_tick,
  output logic usb_low_speed,
  input wire logic token_valid,
  input wire logic [umim_pkg::DEV_ADDR_W-1:0] token_addr,
  input wire logic [umim_pkg::EP_W-1:0] token_ep,
  output logic token_accept,
  input wire logic pc_inc,
  input wire logic pc_jump,
  input wire logic [umim_pkg::PC_W_MAX-1:0] pc_target,
  input wire logic irq_take,
  input wire logic [umim_pkg::VEC_IDX_W-1:0] irq_vector,
  output logic [umim_pkg::PC_W_MAX-1:0] pc,
  input wire logic prog_read,
  input wire logic [7:0] prog_rom_data,
  input wire logic security_fuse,
  output logic [7:0] prog_rd_data,
  input wire logic ram_rd,
  input wire logic ram_wr,
  input wire logic [umim_pkg::RAM_AW-1:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  output logic [7:0] ram_rdata,
  output logic ram_fifo_hit,
  input wire logic call_op,
  input wire logic ret_op,
  input wire logic push_op,
  input wire logic pop_op,
  input wire logic [7:0] push_data,
  output logic [7:0] pop_data,
  input wire logic dsp_load,
  input wire logic [7:0] dsp_value,
  output logic [7:0] call_stack_pointer,
  output logic [7:0] data_stack_pointer,
  input wire logic io_read_instruction,
  input wire logic io_write_instruction,
  input wire logic io_indexed_write_instruction,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  input wire logic [7:0] port0_pins,
  input wire logic [7:0] port1_pins,
  input wire logic cext_pin,
  input wire logic [7:0] timer_value,
  input wire logic wd_tick,
  output logic [7:0] port0_data,
  output logic [7:0] port1_data,
  output logic [7:0] port0_irq_enable,
  output logic [7:0] port1_irq_enable,
  output logic [7:0] port0_pullup_ctrl,
  output logic [7:0] port1_pullup_ctrl,
  output logic [7:0] endpoint0_tx_config,
  output logic [7:0] endpoint1_tx_config,
  output logic [7:0] usb_device_address,
  output logic [7:0] usb_status_control,
  output logic [7:0] endpoint0_rx_status,
  output logic [7:0] global_interrupt_enable,
  output logic cext_oe_b,
  output logic [2*umim_pkg::PORT_PINS*umim_pkg::SINK_W-1:0] sink_current,
  output logic [7:0] processor_status_control,
  output logic watchdog_clear_port,
  output logic watchdog_reset
);
  import umim_pkg::*;

  localparam int PC_W = $clog2(PROG_BYTES);
  localparam int SINK_N = 2 * PORT_PINS;

  // clock doubling: one core tick per resonator edge
  logic osc_sync_reg;
  logic osc_last_reg;
  logic core_tick_reg;
  logic osc_edge;
  assign osc_edge = osc_sync_reg ^ osc_last_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      osc_sync_reg <= 1'b0;
      osc_last_reg <= 1'b0;
      core_tick_reg <= 1'b0;
    end else begin
      osc_sync_reg <= osc_in;
      osc_last_reg <= osc_sync_reg;
      core_tick_reg <= osc_edge;
    end
  end
  assign core_tick = core_tick_reg;

  // fixed low-speed select, no full-speed path exists
  logic low_speed_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) low_speed_reg <= 1'b0;
    else low_speed_reg <= 1'b1;
  end
  assign usb_low_speed = low_speed_reg;

  // i/o decode
  logic io_wr;
  logic [7:0] io_sel_addr;
  assign io_wr = io_write_instruction | io_indexed_write_instruction;
  assign io_sel_addr = io_addr;

  logic wr_p0d, wr_p1d, wr_p0ie, wr_p1ie, wr_p0pu, wr_p1pu;
  logic wr_ep0c, wr_ep1c, wr_da, wr_usc, wr_ep0r, wr_gie;
  logic wr_wd, wr_rc, wr_psc, wr_sink;
  assign wr_p0d = io_wr && io_sel_addr == A_PORT0_DATA;
  assign wr_p1d = io_wr && io_sel_addr == A_PORT1_DATA;
  assign wr_p0ie = io_wr && io_sel_addr == A_PORT0_IE;
  assign wr_p1ie = io_wr && io_sel_addr == A_PORT1_IE;
  assign wr_p0pu = io_wr && io_sel_addr == A_PORT0_PULLUP;
  assign wr_p1pu = io_wr && io_sel_addr == A_PORT1_PULLUP;
  assign wr_ep0c = io_wr && io_sel_addr == A_EP0_TX_CFG;
  assign wr_ep1c = io_wr && io_sel_addr == A_EP1_TX_CFG;
  assign wr_da = io_wr && io_sel_addr == A_USB_DEV_ADDR;
  assign wr_usc = io_wr && io_sel_addr == A_USB_STAT_CTRL;
  assign wr_ep0r = io_wr && io_sel_addr == A_EP0_RX_STAT;
  assign wr_gie = io_wr && io_sel_addr == A_GLOBAL_IE;
  assign wr_wd = io_wr && io_sel_addr == A_WD_CLEAR;
  assign wr_rc = io_wr && io_sel_addr == A_RC_TIMING;
  assign wr_psc = io_wr && io_sel_addr == A_PROC_STAT_CTRL;
  assign wr_sink = io_wr && io_sel_addr[7:4] == A_SINK_BASE[7:4];

  // watchdog
  logic wd_fire;
  umim_watchdog #(
    .CNT_W(WD_CNT_W)
  ) u_watchdog (
    .clock(clock),
    .rst_b(rst_b),
    .tick(wd_tick),
    .restart(wr_wd),
    .fire(wd_fire)
  );

  logic wd_clear_reg;
  logic wd_reset_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wd_clear_reg <= 1'b0;
      wd_reset_reg <= 1'b0;
    end else begin
      wd_clear_reg <= wr_wd;
      wd_reset_reg <= wd_fire;
    end
  end
  assign watchdog_clear_port = wd_clear_reg;
  assign watchdog_reset = wd_reset_reg;

  // plain read/write and write-only registers, all eight bits
  logic [7:0] p0d_reg, p1d_reg, p0ie_reg, p1ie_reg, p0pu_reg, p1pu_reg;
  logic [7:0] ep0c_reg, ep1c_reg, usc_reg, ep0r_reg, gie_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      p0d_reg <= RST_ZERO;
      p1d_reg <= RST_ZERO;
      p0ie_reg <= RST_ZERO;
      p1ie_reg <= RST_ZERO;
      p0pu_reg <= RST_ZERO;
      p1pu_reg <= RST_ZERO;
      ep0c_reg <= RST_ZERO;
      ep1c_reg <= RST_ZERO;
      usc_reg <= RST_ZERO;
      ep0r_reg <= RST_ZERO;
      gie_reg <= RST_ZERO;
    end else begin
      if (wr_p0d) p0d_reg <= io_wdata;
      if (wr_p1d) p1d_reg <= io_wdata;
      if (wr_p0ie) p0ie_reg <= io_wdata;
      if (wr_p1ie) p1ie_reg <= io_wdata;
      if (wr_p0pu) p0pu_reg <= io_wdata;
      if (wr_p1pu) p1pu_reg <= io_wdata;
      if (wr_ep0c) ep0c_reg <= io_wdata;
      if (wr_ep1c) ep1c_reg <= io_wdata;
      if (wr_usc) usc_reg <= io_wdata;
      if (wr_ep0r) ep0r_reg <= io_wdata;
      if (wr_gie) gie_reg <= io_wdata;
    end
  end

  // device address: a watchdog reset clears it and wins over a write
  logic [7:0] da_reg;
  logic [7:0] da_next;
  assign da_next = wd_fire ? RST_ZERO : wr_da ? io_wdata : da_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) da_reg <= RST_ZERO;
    else da_reg <= da_next;
  end

  // processor status and control: run only clears, wdr flag sets
  logic [7:0] psc_reg;
  logic [7:0] psc_wr_val;
  logic [7:0] psc_next;
  assign psc_wr_val = (io_wdata & PROC_STAT_WR_MASK) |
                      (psc_reg & ~PROC_STAT_WR_MASK);
  always_comb begin
    psc_next = wr_psc ? psc_wr_val : psc_reg;
    psc_next[PSC_RUN] = psc_reg[PSC_RUN] &
                        (~wr_psc | io_wdata[PSC_RUN]);
    if (wd_fire) psc_next[PSC_WDR] = 1'b1;
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) psc_reg <= RST_PROC_STAT;
    else psc_reg <= psc_next;
  end

  // rc timing pin: bit 0 low drives the pin low
  logic [7:0] rc_reg;
  logic cext_oe_b_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rc_reg <= RST_RC_TIMING;
      cext_oe_b_reg <= 1'b1;
    end else begin
      if (wr_rc) rc_reg <= io_wdata & RST_RC_TIMING;
      cext_oe_b_reg <= wr_rc ? io_wdata[0] : rc_reg[0];
    end
  end

  // sink current registers, one per pin; missing port 1 pins ignored
  logic [SINK_N*SINK_W-1:0] sink_reg;
  genvar gi;
  generate
    for (gi = 0; gi < SINK_N; gi++) begin : g_sink
      localparam bit PIN_OK = (gi < PORT_PINS) ||
                              (gi - PORT_PINS < P1_PINS);
      logic hit;
      assign hit = wr_sink && PIN_OK &&
                   io_sel_addr[3:0] == 4'(gi);
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) sink_reg[gi*SINK_W +: SINK_W] <= '0;
        else if (hit) sink_reg[gi*SINK_W +: SINK_W] <= io_wdata[SINK_W-1:0];
      end
    end
  endgenerate

  // read mux: write-only and unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb begin
    case (io_sel_addr)
      A_PORT0_DATA: rd_mux = port0_pins;
      A_PORT1_DATA: rd_mux = port1_pins;
      A_EP0_TX_CFG: rd_mux = ep0c_reg;
      A_EP1_TX_CFG: rd_mux = ep1c_reg;
      A_USB_DEV_ADDR: rd_mux = da_reg;
      A_USB_STAT_CTRL: rd_mux = usc_reg;
      A_EP0_RX_STAT: rd_mux = ep0r_reg;
      A_GLOBAL_IE: rd_mux = gie_reg;
      A_RC_TIMING: rd_mux = {7'h00, cext_pin};
      A_TIMER: rd_mux = timer_value;
      A_PROC_STAT_CTRL: rd_mux = psc_reg;
      default: rd_mux = RST_ZERO;
    endcase
  end

  logic [7:0] io_rdata_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) io_rdata_reg <= RST_ZERO;
    else if (io_read_instruction) io_rdata_reg <= rd_mux;
  end

  // usb token filter: own address and endpoints zero or one only
  logic token_accept_reg;
  logic ep_ok;
  assign ep_ok = token_ep <= EP_W'(1);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) token_accept_reg <= 1'b0;
    else token_accept_reg <= token_valid && ep_ok &&
                             token_addr == da_reg[DEV_ADDR_W-1:0];
  end

  // program counter, wraps within program memory
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  logic [PC_W-1:0] vec_addr;
  assign vec_addr = PC_W'(irq_vector) * PC_W'(VEC_BYTES);
  assign pc_next = irq_take ? vec_addr :
                   pc_jump ? pc_target[PC_W-1:0] :
                   pc_inc ? pc_reg + 1'b1 : pc_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) pc_reg <= '0;
    else pc_reg <= pc_next;
  end
  assign pc = PC_W_MAX'(pc_reg);

  // programmer read path
  logic [7:0] prog_rd_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) prog_rd_reg <= RST_ZERO;
    else if (prog_read)
      prog_rd_reg <= security_fuse ? SECURED_READ : prog_rom_data;
  end

  // stack pointers
  logic [7:0] psp_reg;
  logic [7:0] dsp_reg;
  logic [7:0] dsp_dec;
  assign dsp_dec = dsp_reg - DATA_STEP;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      psp_reg <= RST_ZERO;
      dsp_reg <= RST_ZERO;
    end else begin
      if (call_op) psp_reg <= psp_reg + CALL_STEP;
      else if (ret_op) psp_reg <= psp_reg - CALL_STEP;
      if (dsp_load) dsp_reg <= dsp_value;
      else if (push_op) dsp_reg <= dsp_dec;
      else if (pop_op) dsp_reg <= dsp_reg + DATA_STEP;
    end
  end

  // data ram; stack pointer indexes wrap to seven bits
  logic [7:0] ram_mem [RAM_BYTES];
  logic [RAM_AW-1:0] wr_addr;
  logic [RAM_AW-1:0] rd_addr;
  logic ram_we;
  assign ram_we = push_op | ram_wr;
  assign wr_addr = push_op ? dsp_dec[RAM_AW-1:0] : ram_addr;
  assign rd_addr = pop_op ? dsp_reg[RAM_AW-1:0] : ram_addr;

  always_ff @(posedge clock) begin
    if (ram_we) ram_mem[wr_addr] <= push_op ? push_data : ram_wdata;
  end

  logic [7:0] ram_rdata_reg;
  logic [7:0] pop_data_reg;
  logic fifo_hit_reg;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ram_rdata_reg <= RST_ZERO;
      pop_data_reg <= RST_ZERO;
      fifo_hit_reg <= 1'b0;
    end else begin
      if (ram_rd) ram_rdata_reg <= ram_mem[rd_addr];
      if (pop_op) pop_data_reg <= ram_mem[rd_addr];
      fifo_hit_reg <= (ram_rd | ram_wr) &&
                      ram_addr >= EP0_FIFO_BASE;
    end
  end

  assign prog_rd_data = prog_rd_reg;
  assign ram_rdata = ram_rdata_reg;
  assign ram_fifo_hit = fifo_hit_reg;
  assign pop_data = pop_data_reg;
  assign call_stack_pointer = psp_reg;
  assign data_stack_pointer = dsp_reg;
  assign io_rdata = io_rdata_reg;
  assign token_accept = token_accept_reg;
  assign port0_data = p0d_reg;
  assign port1_data = p1d_reg;
  assign port0_irq_enable = p0ie_reg;
  assign port1_irq_enable = p1ie_reg;
  assign port0_pullup_ctrl = p0pu_reg;
  assign port1_pullup_ctrl = p1pu_reg;
  assign endpoint0_tx_config = ep0c_reg;
  assign endpoint1_tx_config = ep1c_reg;
  assign usb_device_address = da_reg;
  assign usb_status_control = usc_reg;
  assign endpoint0_rx_status = ep0r_reg;
  assign global_interrupt_enable = gie_reg;
  assign cext_oe_b = cext_oe_b_reg;
  assign sink_current = sink_reg;
  assign processor_status_control = psc_reg;
endmodule // umim_io_map

// ==== design/umim_pkg.sv ====
// umim_pkg: constants of the low-speed usb controller memory and i/o map
// assumes: used by umim_io_map and umim_watchdog, 8-bit core data path
package umim_pkg;
  // data path and memory sizes
  localparam int DATA_W = 8;
  localparam int RAM_BYTES = 128;
  localparam int RAM_AW = 7;
  localparam int PROG_SMALL_BYTES = 2048;
  localparam int PROG_LARGE_BYTES = 4096;
  localparam int PC_W_MAX = 12;
  localparam int VEC_AREA_BYTES = 16;
  localparam int VEC_BYTES = 2;
  localparam int VEC_IDX_W = 3;
  localparam int FIFO_BYTES = 8;
  localparam int PORT_PINS = 8;
  localparam int SINK_W = 4;
  localparam int DEV_ADDR_W = 7;
  localparam int EP_W = 4;
  localparam int WD_CNT_W = 4;

  // clocking and usb rate
  localparam int RESONATOR_MHZ = 6;
  localparam int CORE_MHZ = 12;
  localparam int USB_LOW_KBPS = 1500;

  // i/o addresses
  localparam logic [7:0] A_PORT0_DATA = 8'h00;
  localparam logic [7:0] A_PORT1_DATA = 8'h01;
  localparam logic [7:0] A_PORT0_IE = 8'h04;
  localparam logic [7:0] A_PORT1_IE = 8'h05;
  localparam logic [7:0] A_PORT0_PULLUP = 8'h08;
  localparam logic [7:0] A_PORT1_PULLUP = 8'h09;
  localparam logic [7:0] A_EP0_TX_CFG = 8'h10;
  localparam logic [7:0] A_EP1_TX_CFG = 8'h11;
  localparam logic [7:0] A_USB_DEV_ADDR = 8'h12;
  localparam logic [7:0] A_USB_STAT_CTRL = 8'h13;
  localparam logic [7:0] A_EP0_RX_STAT = 8'h14;
  localparam logic [7:0] A_GLOBAL_IE = 8'h20;
  localparam logic [7:0] A_WD_CLEAR = 8'h21;
  localparam logic [7:0] A_RC_TIMING = 8'h22;
  localparam logic [7:0] A_TIMER = 8'h23;
  localparam logic [7:0] A_SINK_BASE = 8'h30;
  localparam logic [7:0] A_SINK_P1_BASE = 8'h38;
  localparam logic [7:0] A_PROC_STAT_CTRL = 8'hff;

  // reset values and fields
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_PROC_STAT = 8'h19;
  localparam logic [7:0] PROC_STAT_WR_MASK = 8'h79;
  localparam int PSC_RUN = 0;
  localparam int PSC_WDR = 6;
  localparam logic [7:0] RST_RC_TIMING = 8'h01;
  localparam logic [7:0] SECURED_READ = 8'hff;
  localparam logic [7:0] CALL_STEP = 8'h02;
  localparam logic [7:0] DATA_STEP = 8'h01;
  localparam logic [RAM_AW-1:0] EP0_FIFO_BASE = 7'h70;
  localparam logic [RAM_AW-1:0] EP1_FIFO_BASE = 7'h78;
endpackage

// ==== design/umim_watchdog.sv ====
// umim_watchdog: 4-bit watchdog count with restart and reset pulse
// assumes: tick is a one-cycle pulse every watchdog period, same clock
`timescale 1ns/100ps
module umim_watchdog #(
  parameter int CNT_W = umim_pkg::WD_CNT_W
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic tick,
  input wire logic restart,
  output logic fire
);
  import umim_pkg::*;

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic msb_rise;
  logic fire_reg;

  // restart wins over a tick in the same cycle
  assign count_next = restart ? '0 :
                      tick ? count_reg + 1'b1 : count_reg;
  assign msb_rise = ~count_reg[CNT_W-1] & count_next[CNT_W-1];
  assign fire = fire_reg;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= '0;
      fire_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      fire_reg <= msb_rise;
    end
  end
endmodule // umim_watchdog

// ==== verif/umim_io_map_props.sv ====
// umim_io_map_props: port checks for umim_io_map
// assumes: bound to umim_io_map, one clock, rst_b async active low
`timescale 1ns/100ps
module umim_io_map_props (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic token_valid,
  input wire logic [6:0] token_addr,
  input wire logic [3:0] token_ep,
  input wire logic token_accept,
  input wire logic [7:0] usb_device_address,
  input wire logic irq_take,
  input wire logic [2:0] irq_vector,
  input wire logic [11:0] pc,
  input wire logic call_op,
  input wire logic push_op,
  input wire logic dsp_load,
  input wire logic [7:0] call_stack_pointer,
  input wire logic [7:0] data_stack_pointer,
  input wire logic prog_read,
  input wire logic security_fuse,
  input wire logic [7:0] prog_rd_data,
  input wire logic io_read_instruction,
  input wire logic io_write_instruction,
  input wire logic io_indexed_write_instruction,
  input wire logic [7:0] io_addr,
  input wire logic [7:0] io_rdata,
  input wire logic watchdog_clear_port
);
  import umim_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  sequence s_wd_write;
    (io_write_instruction || io_indexed_write_instruction) &&
    io_addr == 8'h21;
  endsequence
  sequence s_wo_read;
    io_read_instruction && io_addr inside {8'h04, 8'h05, 8'h08, 8'h09,
    8'h21, [8'h30:8'h3f]};
  endsequence
  AST_START: assert property (
    $rose(rst_b) |-> pc == 12'h000 && call_stack_pointer == 8'h00 &&
    data_stack_pointer == 8'h00) else $error("pointers not cleared");
  AST_CALL: assert property (
    call_op |=> call_stack_pointer == $past(call_stack_pointer) + 8'h02)
    else $error("call step wrong");
  AST_PUSH: assert property (
    push_op && !dsp_load |=>
    data_stack_pointer == $past(data_stack_pointer) - 8'h01)
    else $error("push step wrong");
  AST_FUSE: assert property (
    prog_read && security_fuse |=> prog_rd_data == 8'hff)
    else $error("secured read not masked");
  AST_VECTOR: assert property (
    irq_take |=> pc == {8'h00, $past(irq_vector), 1'b0})
    else $error("vector address wrong");
  AST_WO_READ: assert property (
    s_wo_read |=> io_rdata == 8'h00) else $error("write-only read not 0");
  AST_WD_CLEAR: assert property (
    s_wd_write |=> watchdog_clear_port) else $error("no watchdog clear");
  AST_TOKEN: assert property (
    token_accept == $past(token_valid && token_ep <= 4'h1 &&
    token_addr == usb_device_address[6:0])) else $error("token decode");
endmodule // umim_io_map_props

bind umim_io_map umim_io_map_props i_props (
  .clock, .rst_b, .token_valid, .token_addr, .token_ep, .token_accept,
  .usb_device_address, .irq_take, .irq_vector, .pc, .call_op, .push_op,
  .dsp_load, .call_stack_pointer, .data_stack_pointer, .prog_read,
  .security_fuse, .prog_rd_data, .io_read_instruction, .io_write_instruction,
  .io_indexed_write_instruction, .io_addr, .io_rdata, .watchdog_clear_port
);

// ==== verif/umim_core_model.sv ====
// umim_core_model: core side issuing i/o read and write instructions
// assumes: one request at a time, launched 1 ns after a rising edge
`timescale 1ns/100ps
module umim_core_model (
  input wire logic clock,
  input wire logic [7:0] io_rdata,
  output logic io_read_instruction,
  output logic io_write_instruction,
  output logic io_indexed_write_instruction,
  output logic [7:0] io_addr,
  output logic [7:0] io_wdata
);
  initial begin
    {io_read_instruction, io_write_instruction,
      io_indexed_write_instruction, io_addr, io_wdata} = '0;
  end
  // released lines show the inverse of the last value
  task automatic io_wr(input logic [7:0] a, d, input logic idx);
    @(posedge clock);
    #1;
    {io_addr, io_wdata} = {a, d};
    io_write_instruction = !idx;
    io_indexed_write_instruction = idx;
    @(posedge clock);
    #1;
    {io_write_instruction, io_indexed_write_instruction} = 2'b00;
    {io_addr, io_wdata} = ~{a, d};
  endtask
  task automatic io_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    io_addr = a;
    io_read_instruction = 1'b1;
    @(posedge clock);
    #1;
    io_read_instruction = 1'b0;
    io_addr = ~a;
    d = io_rdata;
  endtask
endmodule // umim_core_model

// ==== verif/umim_io_map_test.sv ====
// umim_io_map_test: self-checking bench for umim_io_map
// assumes: umim_core_model issues the i/o instructions
`timescale 1ns/100ps
module umim_io_map_test;
  import umim_pkg::*;
  localparam int P1_COUNT = 4;
  logic clock, rst_b, osc_in, core_tick, usb_low_speed, token_valid;
  logic token_accept, pc_inc, pc_jump, irq_take, prog_read, security_fuse;
  logic ram_rd, ram_wr, ram_fifo_hit, call_op, ret_op, push_op, pop_op;
  logic dsp_load, cext_pin, wd_tick, cext_oe_b, watchdog_clear_port;
  logic io_read_instruction, io_write_instruction, watchdog_reset;
  logic io_indexed_write_instruction;
  logic [2:0] irq_vector;
  logic [3:0] token_ep;
  logic [6:0] token_addr, ram_addr;
  logic [11:0] pc_target, pc;
  logic [63:0] sink_current;
  logic [7:0] prog_rom_data, prog_rd_data, ram_wdata, ram_rdata, push_data;
  logic [7:0] pop_data, dsp_value, call_stack_pointer, data_stack_pointer;
  logic [7:0] io_addr, io_wdata, io_rdata, port0_pins, port1_pins;
  logic [7:0] timer_value, port0_data, port1_data, port0_irq_enable;
  logic [7:0] port1_irq_enable, port0_pullup_ctrl, port1_pullup_ctrl;
  logic [7:0] endpoint0_tx_config, endpoint1_tx_config, usb_device_address;
  logic [7:0] usb_status_control, endpoint0_rx_status;
  logic [7:0] global_interrupt_enable, processor_status_control;
  int mismatches, n_compared, cycles, n_tick, n_wdr;

  umim_io_map #(.P1_PINS(P1_COUNT)) i_dut (.*);
  umim_core_model i_core (.*);

  initial clock = 1'b0;
  always #20 clock = ~clock;
  always @(posedge clock) begin
    n_tick += core_tick;
    n_wdr += watchdog_reset;
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      end_of_test;
    end
  end

  task automatic tick1;
    @(posedge clock);
    #1;
  endtask
  task automatic check(input logic [63:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic do_reset;
    rst_b = 1'b0;
    repeat (3) @(posedge clock);
    #1;
    rst_b = 1'b1;
  endtask
  task automatic t_reset;
    check(pc, 12'h000);
    check(call_stack_pointer, 8'h00);
    check(data_stack_pointer, 8'h00);
    tick1;
    check(usb_low_speed, 1'b1);
  endtask
  task automatic t_clock;
    n_tick = 0;
    repeat (10) begin
      osc_in = ~osc_in;
      repeat (3) tick1;
    end
    repeat (3) tick1;
    // five resonator periods give twice as many core ticks
    check(n_tick, 2 * 5);
  endtask
  task automatic t_prog;
    pc_target = 12'h7fe;
    pc_jump = 1'b1;
    tick1;
    pc_jump = 1'b0;
    pc_inc = 1'b1;
    repeat (2) tick1;
    pc_inc = 1'b0;
    check(pc, 12'h000);
    irq_vector = 3'h5;
    irq_take = 1'b1;
    tick1;
    irq_take = 1'b0;
    check(pc, 12'h00a);
    prog_rom_data = 8'h3c;
    for (int f = 0; f < 2; f++) begin
      security_fuse = f[0];
      prog_read = 1'b1;
      tick1;
      prog_read = 1'b0;
      check(prog_rd_data, f ? 8'hff : 8'h3c);
      tick1;
    end
  endtask
  task automatic t_token;
    i_core.io_wr(8'h12, 8'h05, 1'b0);
    check(usb_device_address, 8'h05);
    for (int k = 0; k < 4; k++) begin
      token_addr = (k == 3) ? 7'h06 : 7'h05;
      token_ep = (k == 3) ? 4'h1 : 4'(k);
      token_valid = 1'b1;
      tick1;
      token_valid = 1'b0;
      check(token_accept, k < 2);
      tick1;
    end
  endtask
  task automatic stk(input bit psh, input logic [7:0] d, sp);
    push_data = d;
    push_op = psh;
    pop_op = !psh;
    tick1;
    push_op = 1'b0;
    pop_op = 1'b0;
    check(data_stack_pointer, sp);
    if (!psh) check(pop_data, d);
    tick1;
  endtask
  task automatic t_stack;
    repeat (3) begin
      call_op = 1'b1;
      tick1;
      call_op = 1'b0;
      tick1;
    end
    ret_op = 1'b1;
    tick1;
    ret_op = 1'b0;
    check(call_stack_pointer, 8'h04);
    stk(1'b1, 8'h81, 8'hff);
    stk(1'b0, 8'h81, 8'h00);
    dsp_value = 8'h70;
    dsp_load = 1'b1;
    tick1;
    dsp_load = 1'b0;
    stk(1'b1, 8'ha5, 8'h6f);
    stk(1'b1, 8'h5b, 8'h6e);
    stk(1'b0, 8'h5b, 8'h6f);
    stk(1'b0, 8'ha5, 8'h70);
  endtask
  task automatic t_sink;
    logic [7:0] d;
    for (int i = 0; i < 16; i++)
      i_core.io_wr(8'h30 + 8'(i), 8'(i + 1), i[0]);
    for (int i = 0; i < 16; i++)
      check(sink_current[4*i +: 4], (i < 8 + P1_COUNT) ? (i + 1) % 16 : 0);
    i_core.io_rd(8'h31, d);
    check(d, 8'h00);
  endtask
  task automatic t_ram;
    for (int k = 0; k < 2; k++) begin
      ram_addr = k ? 7'h75 : 7'h10;
      ram_wdata = 8'h3e + 8'(k);
      ram_wr = 1'b1;
      tick1;
      ram_wr = 1'b0;
      check(ram_fifo_hit, k);
      ram_rd = 1'b1;
      tick1;
      ram_rd = 1'b0;
      check(ram_rdata, 8'h3e + 8'(k));
      check(ram_fifo_hit, k);
    end
  endtask
  task automatic wd_pulse;
    wd_tick = 1'b1;
    tick1;
    wd_tick = 1'b0;
    tick1;
  endtask
  task automatic t_wd;
    i_core.io_wr(8'h21, 8'h00, 1'b0);
    check(watchdog_clear_port, 1'b1);
    n_wdr = 0;
    repeat (7) wd_pulse;
    i_core.io_wr(8'h21, 8'h9c, 1'b1);
    repeat (7) wd_pulse;
    repeat (3) tick1;
    check(n_wdr, 0);
    wd_pulse;
    repeat (3) tick1;
    check(n_wdr, 1);
    check(usb_device_address, 8'h00);
    check(processor_status_control, 8'h59);
  endtask
  task automatic t_regs;
    logic [7:0] d;
    logic [7:0] a [12] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h20,
      8'h04, 8'h05, 8'h08, 8'h09, 8'h21, 8'h40};
    check(pc, 12'h000);
    check(processor_status_control, 8'h19);
    check(cext_oe_b, 1'b1);
    for (int k = 0; k < 12; k++) begin
      i_core.io_wr(a[k], 8'h40 + 8'(k), 1'b0);
      i_core.io_rd(a[k], d);
      check(d, k < 6 ? 8'h40 + 8'(k) : 8'h00);
    end
    check(port0_irq_enable, 8'h46);
    check(port1_irq_enable, 8'h47);
    check(endpoint0_tx_config, 8'h40);
    check(endpoint1_tx_config, 8'h41);
    check(usb_device_address, 8'h42);
    check(usb_status_control, 8'h43);
    check(endpoint0_rx_status, 8'h44);
    check(global_interrupt_enable, 8'h45);
    check(port0_pullup_ctrl, 8'h48);
    check(port1_pullup_ctrl, 8'h49);
    i_core.io_wr(8'h00, 8'h5a, 1'b1);
    i_core.io_wr(8'h01, 8'ha5, 1'b0);
    check(port0_data, 8'h5a);
    check(port1_data, 8'ha5);
    // low cext bit drives the open-drain pin, high releases it
    i_core.io_wr(8'h22, 8'h00, 1'b0);
    check(cext_oe_b, 1'b0);
    i_core.io_wr(8'h22, 8'hff, 1'b1);
    check(cext_oe_b, 1'b1);
    port0_pins = 8'hc3;
    timer_value = 8'h5d;
    i_core.io_wr(8'h23, 8'h00, 1'b0);
    i_core.io_rd(8'h23, d);
    check(d, 8'h5d);
    i_core.io_rd(8'h00, d);
    check(d, 8'hc3);
  endtask

  initial begin
    {osc_in, token_valid, token_addr, token_ep, pc_inc, pc_jump, pc_target,
      irq_take, irq_vector, prog_read, prog_rom_data, security_fuse, ram_rd,
      ram_wr, ram_addr, ram_wdata, call_op, ret_op, push_op, pop_op,
      push_data, dsp_load, dsp_value, cext_pin, timer_value, wd_tick,
      port0_pins, port1_pins} = '0;
    do_reset;
    t_reset;
    t_clock;
    t_prog;
    t_token;
    t_stack;
    t_ram;
    t_sink;
    t_wd;
    do_reset;
    t_regs;
    end_of_test;
  end
endmodule // umim_io_map_test
